//--- logic/ict_pkg.sv
// Constants, form table and types for the instruction cycle timing block
package ict_pkg;
  localparam int FORM_W = 6;
  localparam int FORM_COUNT = 42;
  localparam int CNT_W = 24;
  localparam int ADDR_W = 5;
  localparam int LEN_W = 3;
  localparam int REP_W_DEF = 16;

  // Address calculation clocks by component mix
  localparam logic [ADDR_W-1:0] ADDR_T_DIRECT = 5'h06;
  localparam logic [ADDR_W-1:0] ADDR_T_ONE_REG = 5'h05;
  localparam logic [ADDR_W-1:0] ADDR_T_OFS_ONE = 5'h09;
  localparam logic [ADDR_W-1:0] ADDR_T_PAIR_FAST = 5'h07;
  localparam logic [ADDR_W-1:0] ADDR_T_PAIR_SLOW = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_T_DPAIR_FAST = 5'h0b;
  localparam logic [ADDR_W-1:0] ADDR_T_DPAIR_SLOW = 5'h0c;
  localparam logic [ADDR_W-1:0] ADDR_T_SEG_OVR = 5'h02;
  localparam logic [7:0] WORD_PENALTY = 8'h04;

  typedef enum logic [1:0] {BASE_NONE, BASE_REG_B, BASE_POINTER_REG}
    ict_base_e;
  typedef enum logic [1:0] {IDX_NONE, IDX_SRC_REG, IDX_DEST_REG}
    ict_index_e;

  typedef enum logic [FORM_W-1:0] {
    F_ADJ_ADD, F_ADJ_DIV, F_ADJ_MUL, F_ADJ_SUB,
    F_ARI_RR, F_ARI_RM, F_ARI_MR, F_ARI_RI, F_ARI_MI, F_ARI_AI,
    F_COMPARE_RR, F_COMPARE_RM, F_COMPARE_MR, F_COMPARE_RI,
    F_COMPARE_MI, F_COMPARE_AI, F_STRCMP_ONE, F_STRCMP_REP,
    F_CALL_NEAR, F_CALL_FAR, F_CALL_MEM16, F_CALL_REG16, F_CALL_MEM32,
    F_FLAG_OP, F_STEP_R16, F_STEP_R8, F_STEP_MEM,
    F_SDIV_R8, F_SDIV_R16, F_SDIV_M8, F_SDIV_M16,
    F_SMUL_R8, F_SMUL_R16, F_SMUL_M8, F_SMUL_M16,
    F_IN_IMM, F_IN_PORT_REG, F_INT_BRK, F_INT_N, F_MASKINT_ACK,
    F_ESCAPE_MEM, F_ESCAPE_REG
  } ict_form_e;

  typedef struct packed {
    logic [7:0] cmin;
    logic [7:0] cmax;
    logic [7:0] rep_clk;
    logic [2:0] xfer;
    logic [1:0] rep_xfer;
    logic uses_addr;
    logic stack;
    logic [LEN_W-1:0] len_min;
    logic [LEN_W-1:0] len_max;
  } ict_entry_s;

  // cmin, cmax, per-repeat clocks, transfers, per-repeat transfers,
  // address time used, all transfers are words, length range
  // Rows in form order hold the per-form counts
  localparam ict_entry_s FORM_TAB [FORM_COUNT] = '{
    '{8'h04, 8'h04, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h1, 3'h1},
    '{8'h3c, 8'h3c, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h2, 3'h2},
    '{8'h53, 8'h53, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h1, 3'h1},
    '{8'h04, 8'h04, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h1, 3'h1},
    '{8'h03, 8'h03, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h2, 3'h2},
    '{8'h09, 8'h09, 8'h00, 3'h1, 2'h0, 1'b1, 1'b0, 3'h2, 3'h4},
    '{8'h10, 8'h10, 8'h00, 3'h2, 2'h0, 1'b1, 1'b0, 3'h2, 3'h4},
    '{8'h04, 8'h04, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h3, 3'h4},
    '{8'h11, 8'h11, 8'h00, 3'h2, 2'h0, 1'b1, 1'b0, 3'h3, 3'h6},
    '{8'h04, 8'h04, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h2, 3'h3},
    '{8'h03, 8'h03, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h2, 3'h2},
    '{8'h09, 8'h09, 8'h00, 3'h1, 2'h0, 1'b1, 1'b0, 3'h2, 3'h4},
    '{8'h09, 8'h09, 8'h00, 3'h1, 2'h0, 1'b1, 1'b0, 3'h2, 3'h4},
    '{8'h04, 8'h04, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h3, 3'h4},
    '{8'h0a, 8'h0a, 8'h00, 3'h1, 2'h0, 1'b1, 1'b0, 3'h3, 3'h6},
    '{8'h04, 8'h04, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h2, 3'h3},
    '{8'h16, 8'h16, 8'h00, 3'h2, 2'h0, 1'b0, 1'b0, 3'h1, 3'h1},
    '{8'h09, 8'h09, 8'h16, 3'h0, 2'h2, 1'b0, 1'b0, 3'h1, 3'h1},
    '{8'h13, 8'h13, 8'h00, 3'h1, 2'h0, 1'b0, 1'b1, 3'h3, 3'h3},
    '{8'h1c, 8'h1c, 8'h00, 3'h2, 2'h0, 1'b0, 1'b1, 3'h5, 3'h5},
    '{8'h15, 8'h15, 8'h00, 3'h2, 2'h0, 1'b1, 1'b1, 3'h2, 3'h4},
    '{8'h10, 8'h10, 8'h00, 3'h1, 2'h0, 1'b0, 1'b1, 3'h2, 3'h2},
    '{8'h25, 8'h25, 8'h00, 3'h4, 2'h0, 1'b1, 1'b1, 3'h2, 3'h4},
    '{8'h02, 8'h02, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h1, 3'h1},
    '{8'h02, 8'h02, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h1, 3'h1},
    '{8'h03, 8'h03, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h2, 3'h2},
    '{8'h0f, 8'h0f, 8'h00, 3'h2, 2'h0, 1'b1, 1'b0, 3'h2, 3'h4},
    '{8'h65, 8'h70, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h2, 3'h2},
    '{8'ha5, 8'hb8, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h2, 3'h2},
    '{8'h6b, 8'h76, 8'h00, 3'h1, 2'h0, 1'b1, 1'b0, 3'h2, 3'h4},
    '{8'hab, 8'hbe, 8'h00, 3'h1, 2'h0, 1'b1, 1'b0, 3'h2, 3'h4},
    '{8'h50, 8'h62, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h2, 3'h2},
    '{8'h80, 8'h9a, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h2, 3'h2},
    '{8'h56, 8'h68, 8'h00, 3'h1, 2'h0, 1'b1, 1'b0, 3'h2, 3'h4},
    '{8'h86, 8'ha0, 8'h00, 3'h1, 2'h0, 1'b1, 1'b0, 3'h2, 3'h4},
    '{8'h0a, 8'h0a, 8'h00, 3'h1, 2'h0, 1'b0, 1'b0, 3'h2, 3'h2},
    '{8'h08, 8'h08, 8'h00, 3'h1, 2'h0, 1'b0, 1'b0, 3'h1, 3'h1},
    '{8'h34, 8'h34, 8'h00, 3'h5, 2'h0, 1'b0, 1'b1, 3'h1, 3'h1},
    '{8'h33, 8'h33, 8'h00, 3'h5, 2'h0, 1'b0, 1'b1, 3'h2, 3'h2},
    '{8'h3d, 8'h3d, 8'h00, 3'h7, 2'h0, 1'b0, 1'b1, 3'h0, 3'h0},
    '{8'h08, 8'h08, 8'h00, 3'h1, 2'h0, 1'b1, 1'b0, 3'h2, 3'h4},
    '{8'h02, 8'h02, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 3'h2, 3'h2}
  };
endpackage

//--- logic/ict_addr_if.sv
// Operand address description and its calculation time
interface ict_addr_if import ict_pkg::*; ();
  ict_base_e base_sel;
  ict_index_e idx_sel;
  logic displacement_on;
  logic seg_override;
  logic [ADDR_W-1:0] addr_clks;

  modport calc(input base_sel, input idx_sel, input displacement_on,
               input seg_override, output addr_clks);
  modport user(output base_sel, output idx_sel, output displacement_on,
               output seg_override, input addr_clks);
endinterface

//--- logic/ict_addr_time.sv
// Operand address calculation time from base, index and displacement
module ict_addr_time import ict_pkg::*; (
  ict_addr_if.calc ai
);
  logic [ADDR_W-1:0] raw;
  logic fast_pair;

  // Pairs with the pointer base and dest index, or b base and src index,
  // are the one-clock-faster combinations
  always_comb begin
    fast_pair = (ai.base_sel == BASE_POINTER_REG && ai.idx_sel == IDX_DEST_REG)
             || (ai.base_sel == BASE_REG_B && ai.idx_sel == IDX_SRC_REG);
    if (ai.base_sel == BASE_NONE && ai.idx_sel == IDX_NONE) begin
      raw = ADDR_T_DIRECT; // direct address is displacement only
    end else if (ai.base_sel == BASE_NONE || ai.idx_sel == IDX_NONE) begin
      raw = ai.displacement_on ? ADDR_T_OFS_ONE : ADDR_T_ONE_REG;
    end else if (ai.displacement_on) begin
      raw = fast_pair ? ADDR_T_DPAIR_FAST : ADDR_T_DPAIR_SLOW;
    end else begin
      raw = fast_pair ? ADDR_T_PAIR_FAST : ADDR_T_PAIR_SLOW;
    end
  end

  // Override surcharge sits on top of every mix
  assign ai.addr_clks = ai.seg_override ? raw + ADDR_T_SEG_OVR : raw;
endmodule

//--- logic/ict_timing.sv
// Instruction cycle timing calculator, top level
module ict_timing import ict_pkg::*; #(
  parameter int REP_W = REP_W_DEF
) (
  input logic mclk,
  input logic arst_n,
  input logic req_valid,
  input logic [FORM_W-1:0] req_form,
  input ict_base_e req_base,
  input ict_index_e req_index,
  input logic req_displacement,
  input logic req_seg_override,
  input logic req_word,
  input logic req_odd,
  input logic bus8_mode,
  input logic [REP_W-1:0] req_rep_count,
  output logic req_ready,
  output logic res_valid,
  output logic res_bad_form,
  output logic [CNT_W-1:0] res_clk_min,
  output logic [CNT_W-1:0] res_clk_max,
  output logic [CNT_W-1:0] res_xfers,
  output logic [ADDR_W-1:0] res_addr_clks,
  output logic [LEN_W-1:0] res_len_min,
  output logic [LEN_W-1:0] res_len_max
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALC = 2'b10
  } ict_state_e;

  ict_state_e state_reg;
  logic ready_reg;
  logic valid_reg;
  logic bad_reg;
  logic [FORM_W-1:0] form_reg;
  ict_base_e base_reg;
  ict_index_e index_reg;
  logic displacement_reg;
  logic seg_reg;
  logic word_reg;
  logic odd_reg;
  logic bus8_reg;
  logic [REP_W-1:0] rep_reg;
  logic [CNT_W-1:0] clk_min_reg;
  logic [CNT_W-1:0] clk_max_reg;
  logic [CNT_W-1:0] xfers_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [LEN_W-1:0] len_min_reg;
  logic [LEN_W-1:0] len_max_reg;

  ict_entry_s ent;
  logic form_ok;
  logic word_hit;
  logic [CNT_W-1:0] rep_c;
  logic [CNT_W-1:0] xfer_next;
  logic [CNT_W-1:0] pen_next;
  logic [ADDR_W-1:0] addr_next;
  logic [CNT_W-1:0] clk_min_next;
  logic [CNT_W-1:0] clk_max_next;
  logic take;

  ict_addr_if aif ();

  assign take = req_valid && ready_reg;

  // Address descriptor goes to the calculator from the captured copy
  assign aif.base_sel = base_reg;
  assign aif.idx_sel = index_reg;
  assign aif.displacement_on = displacement_reg;
  assign aif.seg_override = seg_reg;

  ict_addr_time u_addr (
    .ai(aif.calc)
  );

  // Two-state sequencer: capture, then compute and present
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b1;
      valid_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          valid_reg <= 1'b0;
          if (take) begin
            state_reg <= ST_CALC;
            ready_reg <= 1'b0;
          end
        end
        ST_CALC: begin
          state_reg <= ST_IDLE;
          ready_reg <= 1'b1;
          valid_reg <= 1'b1;
        end
        default: begin
          state_reg <= ST_IDLE;
          ready_reg <= 1'b1;
          valid_reg <= 1'b0;
        end
      endcase
    end
  end

  // Request capture; the bus width mode is sampled with each request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      form_reg <= '0;
      base_reg <= BASE_NONE;
      index_reg <= IDX_NONE;
      displacement_reg <= 1'b0;
      seg_reg <= 1'b0;
      word_reg <= 1'b0;
      odd_reg <= 1'b0;
      bus8_reg <= 1'b0;
      rep_reg <= '0;
    end else if (take) begin
      form_reg <= req_form;
      base_reg <= req_base;
      index_reg <= req_index;
      displacement_reg <= req_displacement;
      seg_reg <= req_seg_override;
      word_reg <= req_word;
      odd_reg <= req_odd;
      bus8_reg <= bus8_mode;
      rep_reg <= req_rep_count;
    end
  end

  // Pure function of the captured request: no history enters, so the
  // same request always costs the same
  always_comb begin
    form_ok = form_reg < FORM_W'(FORM_COUNT);
    ent = form_ok ? FORM_TAB[form_reg] : '0;
    rep_c = CNT_W'(ent.rep_clk) * CNT_W'(rep_reg);
    xfer_next = CNT_W'(ent.xfer)
              + CNT_W'(ent.rep_xfer) * CNT_W'(rep_reg);
    addr_next = ent.uses_addr ? aif.addr_clks : '0;
    // Narrow bus pays on every word; wide bus only on odd words
    word_hit = bus8_reg ? (word_reg || ent.stack)
                        : ((word_reg || ent.stack) && odd_reg);
    pen_next = word_hit ? CNT_W'(WORD_PENALTY) * xfer_next : '0;
    clk_min_next = CNT_W'(ent.cmin) + rep_c + CNT_W'(addr_next)
                 + pen_next;
    clk_max_next = CNT_W'(ent.cmax) + rep_c + CNT_W'(addr_next)
                 + pen_next;
  end

  // Result registers hold until the next result is presented
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bad_reg <= 1'b0;
      clk_min_reg <= '0;
      clk_max_reg <= '0;
      xfers_reg <= '0;
      addr_reg <= '0;
      len_min_reg <= '0;
      len_max_reg <= '0;
    end else if (state_reg == ST_CALC) begin
      bad_reg <= !form_ok;
      clk_min_reg <= clk_min_next;
      clk_max_reg <= clk_max_next;
      xfers_reg <= xfer_next;
      addr_reg <= addr_next;
      len_min_reg <= ent.len_min;
      len_max_reg <= ent.len_max;
    end
  end

  assign req_ready = ready_reg;
  assign res_valid = valid_reg;
  assign res_bad_form = bad_reg;
  assign res_clk_min = clk_min_reg;
  assign res_clk_max = clk_max_reg;
  assign res_xfers = xfers_reg;
  assign res_addr_clks = addr_reg;
  assign res_len_min = len_min_reg;
  assign res_len_max = len_max_reg;

  // Checking helpers: previous request key and its answer
  logic [FORM_W+REP_W+8:0] key_now;
  logic [FORM_W+REP_W+8:0] key_last;
  logic seen_reg;
  logic same_reg;
  logic [CNT_W-1:0] prev_min_reg;
  logic [CNT_W-1:0] prev_max_reg;
  logic calc;

  assign calc = state_reg == ST_CALC;
  assign key_now = {form_reg, base_reg, index_reg, displacement_reg,
                    seg_reg, word_reg, odd_reg, bus8_reg, rep_reg};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      key_last <= '0;
      seen_reg <= 1'b0;
      same_reg <= 1'b0;
      prev_min_reg <= '0;
      prev_max_reg <= '0;
    end else if (calc) begin
      key_last <= key_now;
      seen_reg <= 1'b1;
      same_reg <= seen_reg && key_now == key_last;
      prev_min_reg <= clk_min_reg;
      prev_max_reg <= clk_max_reg;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Plain operand: byte data, no override, no address registers
  logic plain_op;
  assign plain_op = !word_reg && !seg_reg && base_reg == BASE_NONE
                    && index_reg == IDX_NONE;

  handshake_seq_a: assert property (take |=> !req_ready && !res_valid
    ##1 res_valid && req_ready ##1 !res_valid)
    else $error("request not answered two cycles after it was taken");

  addr_direct_a: assert property (calc && form_reg == F_ARI_RM && plain_op
    && displacement_reg |=> res_addr_clks == 5'h06
    && res_clk_min == 24'h00000f)
    else $error("direct address time not six clocks");

  addr_pair_a: assert property (calc && form_reg == F_ARI_MR
    && base_reg == BASE_POINTER_REG && index_reg == IDX_SRC_REG
    && !seg_reg
    |=> res_addr_clks == (displacement_reg ? 5'h0c : 5'h08))
    else $error("slow base plus index address time wrong");

  seg_override_a: assert property (calc && seg_reg && form_reg == F_ESCAPE_MEM
    |=> res_addr_clks == $past(aif.addr_clks)
    && res_addr_clks >= 5'h07)
    else $error("override not added to address time");

  narrow_word_a: assert property (calc && form_reg == F_STEP_MEM && bus8_reg
    && word_reg |=> res_clk_min == 24'h000017 + 24'(res_addr_clks))
    else $error("narrow bus word surcharge wrong");

  wide_even_a: assert property (calc && form_reg == F_CALL_FAR && !bus8_reg
    && !odd_reg |=> res_clk_min == 24'h00001c
    && res_xfers == 24'h000002)
    else $error("far call on even stack not 28 clocks");

  wide_odd_a: assert property (calc && form_reg == F_CALL_FAR && !bus8_reg
    && odd_reg |=> res_clk_min == 24'h000024)
    else $error("odd word surcharge missing on wide bus");

  repeat_same_a: assert property (res_valid && same_reg
    |-> res_clk_min == prev_min_reg && res_clk_max == prev_max_reg)
    else $error("identical requests gave different counts");

  adjust_div_a: assert property (calc && form_reg == F_ADJ_DIV
    |=> res_clk_min == 24'h00003c && res_xfers == '0
    && res_len_min == 3'h2)
    else $error("adjust before divide not 60 clocks");

  adjust_sub_a: assert property (calc && form_reg == F_ADJ_SUB
    |=> res_clk_max == 24'h000004 && res_len_max == 3'h1)
    else $error("adjust after subtract not 4 clocks");

  add_mem_a: assert property (calc && form_reg == F_ARI_MR && !word_reg
    |=> res_clk_min == 24'h000010 + 24'(res_addr_clks)
    && res_xfers == 24'h000002)
    else $error("memory destination add count wrong");

  add_imm_a: assert property (calc && form_reg == F_ARI_MI && !word_reg
    |=> res_clk_min == 24'h000011 + 24'(res_addr_clks))
    else $error("memory immediate add count wrong");

  compare_mi_a: assert property (calc && form_reg == F_COMPARE_MI && !word_reg
    |=> res_clk_min == 24'h00000a + 24'(res_addr_clks)
    && res_xfers == 24'h000001)
    else $error("memory immediate compare count wrong");

  call_mem32_a: assert property (calc && form_reg == F_CALL_MEM32 && !bus8_reg
    && !odd_reg |=> res_clk_min == 24'h000025 + 24'(res_addr_clks))
    else $error("doubleword pointer call count wrong");

  strcmp_rep_a: assert property (calc && form_reg == F_STRCMP_REP && !word_reg
    |=> res_clk_min == 24'h000009 + 24'h000016 * 24'($past(rep_reg))
    && res_xfers == 24'h000002 * 24'($past(rep_reg)))
    else $error("repeated string compare count wrong");

  flag_op_a: assert property (calc && form_reg == F_FLAG_OP
    |=> res_clk_min == 24'h000002 && res_xfers == '0)
    else $error("flag operation not 2 clocks");

  step_reg_a: assert property (calc && form_reg == F_STEP_R8
    |=> res_clk_min == 24'h000003 && res_len_min == 3'h2)
    else $error("byte register step not 3 clocks");

  divide_range_a: assert property (calc && form_reg == F_SDIV_R16
    |=> res_clk_min == 24'h0000a5 && res_clk_max == 24'h0000b8)
    else $error("word register divide range wrong");

  multiply_range_a: assert property (calc && form_reg == F_SMUL_M8
    && !word_reg |=> res_clk_max - res_clk_min == 24'h000012
    && res_clk_min == 24'h000056 + 24'(res_addr_clks))
    else $error("byte memory multiply range wrong");

  port_in_a: assert property (calc && form_reg == F_IN_PORT_REG && !word_reg
    |=> res_clk_min == 24'h000008 && res_xfers == 24'h000001)
    else $error("register port input not 8 clocks");

  soft_int_a: assert property (calc && form_reg == F_INT_BRK && !bus8_reg
    && !odd_reg |=> res_clk_min == 24'h000034
    && res_xfers == 24'h000005)
    else $error("breakpoint interrupt not 52 clocks");

  maskable_ack_a: assert property (calc && form_reg == F_MASKINT_ACK
    && bus8_reg |=> res_xfers == 24'h000007
    && res_clk_min == 24'h00003d + 24'h00001c)
    else $error("maskable interrupt service count wrong");

  escape_reg_a: assert property (calc && form_reg == F_ESCAPE_REG
    |=> res_clk_min == 24'h000002 && res_addr_clks == '0)
    else $error("register escape not 2 clocks");

  add_reg_a: assert property (calc && form_reg == F_ARI_RR
    |=> res_clk_min == 24'h000003 && res_xfers == '0)
    else $error("register add not 3 clocks");

  call_near_a: assert property (calc && form_reg == F_CALL_NEAR && !bus8_reg
    && !odd_reg |=> res_clk_min == 24'h000013)
    else $error("near call not 19 clocks");

  escape_mem_a: assert property (calc && form_reg == F_ESCAPE_MEM && !word_reg
    |=> res_clk_min == 24'h000008 + 24'(res_addr_clks)
    && res_xfers == 24'h000001)
    else $error("memory escape count wrong");

  bad_form_a: assert property (calc && !form_ok |=> res_bad_form
    && res_clk_max == '0 && res_xfers == '0)
    else $error("illegal form not flagged with zero counts");

  range_order_a: assert property (res_valid && !res_bad_form
    |-> res_clk_max >= res_clk_min)
    else $error("maximum below minimum");

  // Main scenarios
  cov_narrow_word: cover property (calc && bus8_reg && word_reg ##1 res_valid);
  cov_rep_compare: cover property (calc && form_reg == F_STRCMP_REP
    && rep_reg > REP_W'(1) ##1 res_valid);
  cov_divide: cover property (calc && form_reg == F_SDIV_M16 ##1 res_valid);
  cov_bad_form: cover property (res_valid && res_bad_form);
  cov_back_to_back: cover property (take ##2 take);
endmodule

//--- dv/ict_timing_tb_top.sv
// Self-checking testbench for the instruction cycle timing block
module ict_timing_tb_top import ict_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic bad;
    logic [CNT_W-1:0] cmn;
    logic [CNT_W-1:0] cmx;
    logic [CNT_W-1:0] xf;
    logic [ADDR_W-1:0] ad;
    logic [LEN_W-1:0] lmn;
    logic [LEN_W-1:0] lmx;
  } ict_exp_s;

  // Base clocks per form, two hex digits each, form 0 leftmost
  localparam logic [335:0] CMIN_TAB = {80'h043c5304030910041104,
    80'h030909040a041609131c, 80'h1510250202030f65a56b,
    80'hab508056860a0834333d, 16'h0802};
  localparam logic [335:0] CMAX_TAB = {80'h043c5304030910041104,
    80'h030909040a041609131c, 80'h1510250202030f70b876,
    80'hbe629a68a00a0834333d, 16'h0802};
  // Transfers per form, one digit each; address and stack flags by form bit
  localparam logic [167:0] XF_TAB =
    168'h000001202001101020122140002001100111155710;
  localparam logic [41:0] ADDR_MAP = 42'h10664505960;
  localparam logic [41:0] STK_MAP = 42'h0e0007c0000;
  // Byte length range per form, one digit each, form 0 leftmost
  localparam logic [167:0] LMIN_TAB =
    168'h121122233222233211352221122222222222112022;
  localparam logic [167:0] LMAX_TAB =
    168'h121124446324446311354241124224422442112042;

  logic mclk, arst_n, req_valid, req_displacement, req_seg_override;
  logic req_word, req_odd, bus8_mode, req_ready, res_valid, res_bad_form;
  logic [FORM_W-1:0] req_form;
  ict_base_e req_base;
  ict_index_e req_index;
  logic [15:0] req_rep_count;
  logic [CNT_W-1:0] res_clk_min, res_clk_max, res_xfers;
  logic [ADDR_W-1:0] res_addr_clks;
  logic [LEN_W-1:0] res_len_min, res_len_max;
  logic [5:0] f;
  logic [1:0] b, x;
  logic d, o, w, od, b8;
  logic [15:0] rep;
  ict_exp_s exp_q[$];
  ict_exp_s got;
  int err_count, total_checks, seed, i, j, k;
  logic [31:0] r;
  logic [5:0] sl[5] = '{6'h06, 6'h12, 6'h27, 6'h11, 6'h04};

  ict_timing dut (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid),
    .req_form(req_form), .req_base(req_base), .req_index(req_index),
    .req_displacement(req_displacement), .req_seg_override(req_seg_override),
    .req_word(req_word), .req_odd(req_odd), .bus8_mode(bus8_mode),
    .req_rep_count(req_rep_count), .req_ready(req_ready),
    .res_valid(res_valid), .res_bad_form(res_bad_form),
    .res_clk_min(res_clk_min), .res_clk_max(res_clk_max),
    .res_xfers(res_xfers), .res_addr_clks(res_addr_clks),
    .res_len_min(res_len_min), .res_len_max(res_len_max));

  // Free-running 50 ns clock
  always #25 mclk = ~mclk;

  // Expected result worked out independently of the design's table
  function automatic ict_exp_s model(input logic [5:0] ff);
    ict_exp_s e;
    logic [4:0] a;
    logic [CNT_W-1:0] ext;
    int kk;
    e = '0;
    if (ff > 6'h29) begin
      e.bad = 1'b1;
      return e;
    end
    kk = 41 - ff;
    e.lmn = LMIN_TAB[4*kk +: 3];
    e.lmx = LMAX_TAB[4*kk +: 3];
    if (b == 2'h0 && x == 2'h0) a = 5'h06;
    else if (b == 2'h0 || x == 2'h0) a = d ? 5'h09 : 5'h05;
    else if (b == x) a = d ? 5'h0b : 5'h07;
    else a = d ? 5'h0c : 5'h08;
    a = a + (o ? 5'h02 : 5'h00);
    e.ad = ADDR_MAP[ff] ? a : 5'h00;
    e.xf = XF_TAB[4*kk +: 4] + ((ff == 6'h11) ? 2 * rep : 0);
    ext = e.ad + ((ff == 6'h11) ? 22 * rep : 0);
    // Odd address only matters on the wide bus
    if ((w | STK_MAP[ff]) & (b8 | od)) ext = ext + 4 * e.xf;
    e.cmn = CMIN_TAB[8*kk +: 8] + ext;
    e.cmx = CMAX_TAB[8*kk +: 8] + ext;
    return e;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  // One request; poke keeps valid up in the busy cycle, which must be ignored
  task automatic send(input bit poke);
    exp_q.push_back(model(f));
    req_valid <= 1'b1;
    req_form <= f;
    req_base <= ict_base_e'(b);
    req_index <= ict_index_e'(x);
    req_displacement <= d;
    req_seg_override <= o;
    req_word <= w;
    req_odd <= od;
    bus8_mode <= b8;
    req_rep_count <= rep;
    @(posedge mclk);
    req_valid <= poke;
    req_form <= 6'h3f;
    @(posedge mclk);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Results arrive in request order; compare each against the oldest note
  always @(posedge mclk) begin
    if (res_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        got = exp_q.pop_front();
        chk({31'h0, res_bad_form}, {31'h0, got.bad});
        chk({8'h0, res_clk_min}, {8'h0, got.cmn});
        chk({8'h0, res_clk_max}, {8'h0, got.cmx});
        chk({8'h0, res_xfers}, {8'h0, got.xf});
        chk({27'h0, res_addr_clks}, {27'h0, got.ad});
        chk({29'h0, res_len_min}, {29'h0, got.lmn});
        chk({29'h0, res_len_max}, {29'h0, got.lmx});
        chk({31'h0, req_ready}, 32'h1);
      end
    end
  end

  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    req_valid = 1'b0;
    req_form = 6'h00;
    req_base = BASE_NONE;
    req_index = IDX_NONE;
    {req_displacement, req_seg_override, req_word, req_odd} = 4'h0;
    bus8_mode = 1'b0;
    req_rep_count = 16'h0000;
    {f, b, x, d, o, w, od, b8, rep} = '0;
    err_count = 0;
    total_checks = 0;
    seed = 38270;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    // Every form plain, no surcharge; every fifth one pokes while busy
    for (i = 0; i < 42; i++) begin
      f = i[5:0];
      rep = (i == 17) ? 16'h0003 : 16'h0000;
      send(i % 5 == 0);
    end
    $display("form sweep done");
    // All base, index, displacement and override mixes on a memory form
    f = 6'h05;
    for (i = 0; i < 36; i++) begin
      b = 2'(i % 3);
      x = 2'((i / 3) % 3);
      d = ((i / 9) % 2 == 1);
      o = (i >= 18);
      send(1'b0);
    end
    $display("address mix done");
    // Word, odd and narrow-bus surcharges, stack forms included
    {b, x, d, o} = '0;
    rep = 16'h0002;
    for (i = 0; i < 5; i++) begin
      for (j = 0; j < 8; j++) begin
        f = sl[i];
        {b8, od, w} = j[2:0];
        send(1'b0);
      end
    end
    $display("surcharge done");
    // Random mix including illegal codes; repeats must match the model
    for (i = 0; i < 300; i++) begin
      r = $random(seed);
      f = 6'($unsigned($random(seed)) % 44);
      b = (r[1:0] == 2'h3) ? 2'h0 : r[1:0];
      x = (r[3:2] == 2'h3) ? 2'h0 : r[3:2];
      {b8, od, w, o, d} = r[8:4];
      rep = {12'h000, r[12:9]};
      send(r[13]);
    end
    $display("random mix done");
    // Same request twice in a row must cost the same
    repeat (2) send(1'b0);
    $display("repeat pair done");
    req_valid <= 1'b0;
    // Bounded drain; anything left over counts as a mismatch
    for (k = 0; k < 10 && exp_q.size() != 0; k++) @(posedge mclk);
    chk(exp_q.size(), 32'h0);
    report_and_stop();
  end
endmodule
